// >>> mbiie_pkg.sv
`default_nettype none

package mbiie_pkg;

  // ****************************************************************
  // core widths and fixed addresses
  // ****************************************************************
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned PC_W       = 10;
  localparam int unsigned INSTR_W    = 18;
  localparam int unsigned REG_COUNT  = 16;
  localparam logic [9:0]  PC_RESET   = 10'h000;
  localparam logic [9:0]  IRQ_VECTOR = 10'h3ff;
  localparam logic [7:0]  BYTE_RESET = 8'h00;

  // ****************************************************************
  // instruction word layout
  // ****************************************************************
  localparam int unsigned OP_LSB    = 13;
  localparam int unsigned COND_LSB  = 10;
  localparam int unsigned DEST_LSB  = 8;
  localparam int unsigned SRC_LSB   = 4;

  typedef enum logic [4:0] {
    OP_LOAD_K   = 5'h00,
    OP_LOAD_R   = 5'h01,
    OP_OR_K     = 5'h02,
    OP_OR_R     = 5'h03,
    OP_FETCH_R  = 5'h04,
    OP_FETCH_S  = 5'h05,
    OP_STORE_R  = 5'h06,
    OP_STORE_S  = 5'h07,
    OP_IN_R     = 5'h08,
    OP_IN_P     = 5'h09,
    OP_OUT_R    = 5'h0a,
    OP_OUT_P    = 5'h0b,
    OP_JUMP     = 5'h0c,
    OP_RETURN   = 5'h0d,
    OP_IRQ_ACCEPT_ON_INSTR  = 5'h0e,
    OP_IRQ_ACCEPT_OFF_INSTR = 5'h0f
  } mbiie_opcode_t;

  // branch condition field, bits [12:10]
  localparam logic [2:0] COND_ALWAYS = 3'h0;
  localparam logic [2:0] COND_Z      = 3'h4;
  localparam logic [2:0] COND_NZ     = 3'h5;
  localparam logic [2:0] COND_C      = 3'h6;
  localparam logic [2:0] COND_NC     = 3'h7;

  // ****************************************************************
  // register bus map
  // ****************************************************************
  localparam int unsigned AXI_ADDR_W   = 4;
  localparam logic [3:0]  ADDR_CTRL    = 4'h0;
  localparam logic [3:0]  ADDR_STATUS  = 4'h4;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic        CTRL_RUN_RESET = 1'b1;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic [7:0] port_select_addr;
    logic [7:0] out_byte;
    logic       write_strobe;
    logic       read_strobe;
  } mbiie_port_t;

  typedef struct packed {
    logic [9:0] spare;
    logic       saved_carry;
    logic       saved_zero;
    logic [5:0] stack_depth;
    logic       irq_accept;
    logic       carry;
    logic       zero;
    logic       running;
    logic [9:0] program_counter;
  } mbiie_status_t;

endpackage

`default_nettype wire

// >>> mbiie_core.sv
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module mbiie_core
  import mbiie_pkg::*;
#(
  parameter int unsigned STACK_DEPTH   = 32,
  parameter int unsigned SCRATCH_DEPTH = 64
) (
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  output logic [PC_W-1:0]            instr_addr,
  input  wire logic [INSTR_W-1:0]    instr_data,
  input  wire logic [DATA_W-1:0]     in_byte,
  output mbiie_port_t                port_bus,
  input  wire logic                  irq_request,
  output logic                       irq_ack,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  localparam int unsigned SP_W = $clog2(STACK_DEPTH);
  localparam int unsigned SC_W = $clog2(SCRATCH_DEPTH);

  if (STACK_DEPTH < 2 || STACK_DEPTH > 32 || (1 << SP_W) != STACK_DEPTH) begin : g_chk_stack
    $error("stack depth must be a power of two from 2 to 32");
  end
  if (SCRATCH_DEPTH < 2 || SCRATCH_DEPTH > 256 || (1 << SC_W) != SCRATCH_DEPTH) begin : g_chk_sc
    $error("scratchpad depth must be a power of two from 2 to 256");
  end

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic mbiie_opcode_t op_of(input logic [INSTR_W-1:0] w);
    return mbiie_opcode_t'(w[INSTR_W-1:OP_LSB]);
  endfunction

  function automatic logic [3:0] dest_of(input logic [INSTR_W-1:0] w);
    return w[DEST_LSB+3:DEST_LSB];
  endfunction

  function automatic logic [3:0] src_of(input logic [INSTR_W-1:0] w);
    return w[SRC_LSB+3:SRC_LSB];
  endfunction

  function automatic logic cond_met(input logic [2:0] c, input logic z, input logic cy);
    case (c)
      COND_ALWAYS: return 1'b1;
      COND_Z:      return z;
      COND_NZ:     return !z;
      COND_C:      return cy;
      COND_NC:     return !cy;
      default:     return 1'b0;
    endcase
  endfunction

  typedef enum logic [2:0] {
    ST_FETCH,
    ST_OP1,
    ST_OP2,
    ST_IRQ1,
    ST_IRQ2
  } mbiie_state_t;

  mbiie_state_t         state;
  mbiie_state_t         next_state;
  logic [INSTR_W-1:0]   instr_q;
  logic [DATA_W-1:0]    regs [REG_COUNT];
  logic [DATA_W-1:0]    scratch [SCRATCH_DEPTH];
  logic [PC_W-1:0]      stack [STACK_DEPTH];
  logic [SP_W-1:0]      sp;
  logic [PC_W-1:0]      program_counter;
  logic                 zero;
  logic                 carry;
  logic                 saved_zero;
  logic                 saved_carry;
  logic                 irq_accept;
  logic                 run;
  logic                 irq_meta;
  logic                 irq_sync;
  mbiie_opcode_t        op;
  logic [3:0]           dest_sel;
  logic [3:0]           src_sel;
  logic [DATA_W-1:0]    dest_register;
  logic [DATA_W-1:0]    source_register;
  logic [DATA_W-1:0]    constant_byte;
  logic [DATA_W-1:0]    or_result;
  logic                 taken;
  logic [PC_W-1:0]      stack_top_value;
  logic                 exec;
  mbiie_opcode_t        f_op;
  logic                 axi_wr_go;
  logic                 axi_rd_go;
  mbiie_status_t        status;

  assign op              = op_of(instr_q);
  assign dest_sel        = dest_of(instr_q);
  assign src_sel         = src_of(instr_q);
  assign dest_register   = regs[dest_sel];
  assign source_register = regs[src_sel];
  assign constant_byte   = instr_q[DATA_W-1:0];
  assign or_result       = dest_register | ((op == OP_OR_K) ? constant_byte : source_register);
  assign taken           = cond_met(instr_q[COND_LSB+2:COND_LSB], zero, carry);
  assign stack_top_value = stack[sp - SP_W'(1)];
  assign exec            = (state == ST_OP2);
  assign f_op            = op_of(instr_data);
  assign instr_addr      = program_counter;

  // ****************************************************************
  // interrupt request synchroniser
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_meta <= 1'b0;
      irq_sync <= 1'b0;
    end else begin
      irq_meta <= irq_request;
      irq_sync <= irq_meta;
    end
  end

  // ****************************************************************
  // sequencer: fetch, two operate cycles, or two event cycles
  // ****************************************************************
  always_comb begin
    next_state = state;
    case (state)
      ST_FETCH: begin
        if (irq_sync && irq_accept) begin
          next_state = ST_IRQ1;
        end else if (run) begin
          next_state = ST_OP1;
        end
      end
      ST_OP1:  next_state = ST_OP2;
      ST_OP2:  next_state = ST_FETCH;
      ST_IRQ1: next_state = ST_IRQ2;
      ST_IRQ2: next_state = ST_FETCH;
      default: next_state = ST_FETCH;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state   <= ST_FETCH;
      instr_q <= '0;
    end else begin
      state <= next_state;
      if (state == ST_FETCH && next_state == ST_OP1) begin
        instr_q <= instr_data;
      end
    end
  end

  // ****************************************************************
  // program counter and call stack
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      program_counter <= PC_RESET;
      sp              <= '0;
    end else if (state == ST_IRQ2) begin
      stack[sp]       <= program_counter;
      sp              <= sp + SP_W'(1);
      program_counter <= IRQ_VECTOR;
    end else if (exec) begin
      if (op == OP_JUMP && taken) begin
        program_counter <= instr_q[PC_W-1:0];
      end else if (op == OP_RETURN && taken) begin
        program_counter <= stack_top_value + PC_W'(1);
        sp              <= sp - SP_W'(1);
      end else begin
        program_counter <= program_counter + PC_W'(1);
      end
    end
  end

  // ****************************************************************
  // register file and scratchpad
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= BYTE_RESET;
      end
    end else if (exec) begin
      case (op)
        OP_LOAD_K:  regs[dest_sel] <= constant_byte;
        OP_LOAD_R:  regs[dest_sel] <= source_register;
        OP_OR_K,
        OP_OR_R:    regs[dest_sel] <= or_result;
        OP_FETCH_R: regs[dest_sel] <= scratch[source_register[SC_W-1:0]];
        OP_FETCH_S: regs[dest_sel] <= scratch[constant_byte[SC_W-1:0]];
        OP_IN_R,
        OP_IN_P:    regs[dest_sel] <= in_byte;
        default:    ;
      endcase
    end
  end

  // no reset on the scratchpad so it can map onto block memory
  always_ff @(posedge clock) begin
    if (exec && op == OP_STORE_R) begin
      scratch[source_register[SC_W-1:0]] <= dest_register;
    end else if (exec && op == OP_STORE_S) begin
      scratch[constant_byte[SC_W-1:0]] <= dest_register;
    end
  end

  // ****************************************************************
  // flags and interrupt acceptance
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      zero        <= 1'b0;
      carry       <= 1'b0;
      saved_zero  <= 1'b0;
      saved_carry <= 1'b0;
      irq_accept  <= 1'b0;
    end else if (state == ST_IRQ2) begin
      saved_zero  <= zero;
      saved_carry <= carry;
      irq_accept  <= 1'b0;
    end else if (exec) begin
      case (op)
        OP_OR_K,
        OP_OR_R: begin
          zero  <= (or_result == BYTE_RESET);
          carry <= 1'b0;
        end
        OP_IRQ_ACCEPT_ON_INSTR:  irq_accept <= 1'b1;
        OP_IRQ_ACCEPT_OFF_INSTR: irq_accept <= 1'b0;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // port interface: address and data held for both operate cycles
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      port_bus <= '0;
      irq_ack  <= 1'b0;
    end else begin
      // strobes are high only in the second operate cycle
      port_bus.write_strobe <= (state == ST_OP1) && (op == OP_OUT_R || op == OP_OUT_P);
      port_bus.read_strobe  <= (state == ST_OP1) && (op == OP_IN_R || op == OP_IN_P);
      irq_ack               <= (state == ST_IRQ1);
      if (next_state == ST_OP1) begin
        case (f_op)
          OP_IN_R,
          OP_OUT_R: port_bus.port_select_addr <= regs[src_of(instr_data)];
          OP_IN_P,
          OP_OUT_P: port_bus.port_select_addr <= instr_data[DATA_W-1:0];
          default:  ;
        endcase
        if (f_op == OP_OUT_R || f_op == OP_OUT_P) begin
          port_bus.out_byte <= regs[dest_of(instr_data)];
        end
      end
    end
  end

  // ****************************************************************
  // register bus slave
  // ****************************************************************
  // address and data are taken together; simpler than two holding
  // registers and still legal for the master
  assign axi_wr_go     = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = axi_wr_go;
  assign s_axi_wready  = axi_wr_go;
  assign s_axi_arready = !s_axi_rvalid;
  assign axi_rd_go     = s_axi_arvalid && s_axi_arready;

  always_comb begin
    status                 = '0;
    status.saved_carry     = saved_carry;
    status.saved_zero      = saved_zero;
    status.stack_depth     = 6'(sp);
    status.irq_accept      = irq_accept;
    status.carry           = carry;
    status.zero            = zero;
    status.running         = run;
    status.program_counter = program_counter;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      run          <= CTRL_RUN_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (axi_wr_go) begin
        s_axi_bvalid <= 1'b1;
        if (s_axi_awaddr[3:2] == ADDR_CTRL[3:2]) begin
          s_axi_bresp <= RESP_OKAY;
          if (s_axi_wstrb[0]) begin
            run <= s_axi_wdata[CTRL_RUN_BIT];
          end
        end else if (s_axi_awaddr[3:2] == ADDR_STATUS[3:2]) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (axi_rd_go) begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr[3:2] == ADDR_CTRL[3:2]) begin
        s_axi_rdata <= 32'(run);
        s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_araddr[3:2] == ADDR_STATUS[3:2]) begin
        s_axi_rdata <= status;
        s_axi_rresp <= RESP_OKAY;
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> mbiie_core_properties.sv
`timescale 1ns/100ps
`default_nettype none

module mbiie_core_properties
  import mbiie_pkg::*;
(
  input wire logic               clock,
  input wire logic               sys_rst,
  input wire logic [PC_W-1:0]    instr_addr,
  input wire logic [INSTR_W-1:0] instr_data,
  input wire mbiie_port_t        port_bus,
  input wire logic               irq_request,
  input wire logic               irq_ack
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  logic [4:0] op;
  logic       ws;
  logic       rs;
  logic [7:0] pa;

  // instr_data still shows the current word until the pc moves
  assign op = instr_data[17:13];
  assign ws = port_bus.write_strobe;
  assign rs = port_bus.read_strobe;
  assign pa = port_bus.port_select_addr;

  // ****************************************************************
  // port, interrupt and jump timing
  // ****************************************************************
  property p_wr_hold;
    $rose(ws) |-> $stable(pa) && $stable(port_bus.out_byte);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("out data moved at strobe");
  property p_wr_pulse;
    ws |=> !ws && $stable(pa) && $stable(port_bus.out_byte);
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  property p_ws_op;
    ws |-> op == OP_OUT_R || op == OP_OUT_P;
  endproperty
  a_ws_op: assert property (p_ws_op) else $error("write strobe without output");
  property p_rd_pulse;
    rs |=> !rs && !ws;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
  property p_out_port;
    ws && op == OP_OUT_P |-> pa == instr_data[7:0];
  endproperty
  a_out_port: assert property (p_out_port) else $error("wrong output port");
  property p_in_port;
    rs && op == OP_IN_P |-> pa == instr_data[7:0];
  endproperty
  a_in_port: assert property (p_in_port) else $error("wrong input port");
  property p_ack_pulse;
    irq_ack |=> !irq_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_req;
    irq_ack |-> $past(irq_request, 4);
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack without request");
  property p_vector;
    irq_ack |=> instr_addr == IRQ_VECTOR;
  endproperty
  a_vector: assert property (p_vector) else $error("no jump to vector");
  property p_jump;
    $changed(instr_addr) && !$past(irq_ack) && $past(op) == OP_JUMP
      && $past(instr_data[12:10]) == COND_ALWAYS |-> instr_addr == $past(instr_data[9:0]);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");

  c_write: cover property (ws);
  c_read: cover property (rs);
  c_ack: cover property (irq_ack);
endmodule

bind mbiie_core mbiie_core_properties u_props (.clock(clock), .sys_rst(sys_rst),
  .instr_addr(instr_addr), .instr_data(instr_data), .port_bus(port_bus),
  .irq_request(irq_request), .irq_ack(irq_ack));

`default_nettype wire

// >>> mbiie_fabric_model.sv
`timescale 1ns/100ps
`default_nettype none

module mbiie_fabric_model
  import mbiie_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire mbiie_port_t port_bus,
  output logic [7:0]       in_byte
);
  logic [15:0] wr_log [0:15];
  logic [7:0]  rd_log [0:15];
  int          wr_n;
  int          rd_n;
  logic [7:0]  resp;

  // ****************************************************************
  // port decode
  // ****************************************************************
  assign resp = port_bus.port_select_addr ^ 8'ha5;
  // inverted outside the capture cycle, so a mistimed sample shows
  assign in_byte = port_bus.read_strobe ? resp : ~resp;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_n <= 0;
      rd_n <= 0;
    end else begin
      if (port_bus.write_strobe) begin
        wr_log[wr_n[3:0]] <= {port_bus.port_select_addr, port_bus.out_byte};
        wr_n <= wr_n + 1;
      end
      if (port_bus.read_strobe) begin
        rd_log[rd_n[3:0]] <= port_bus.port_select_addr;
        rd_n <= rd_n + 1;
      end
    end
  end
endmodule

`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import mbiie_pkg::*;
();
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        irq_request = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        irq_ack, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  logic [9:0]  instr_addr;
  logic [17:0] instr_data;
  logic [7:0]  in_byte;
  mbiie_port_t port_bus;
  logic [17:0] rom [0:1023];
  logic [15:0] exp_wr [0:6] = '{16'h105a, 16'h5adb, 16'h3085, 16'h31ff, 16'h405a,
                               16'h415a, 16'h425a};
  int          fail_count = 0;
  int          check_count = 0;
  int          ack_count = 0;

  mbiie_core DUT (.clock, .sys_rst, .instr_addr, .instr_data, .in_byte, .port_bus,
    .irq_request, .irq_ack, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  mbiie_fabric_model FAB (.clock, .sys_rst, .port_bus, .in_byte);

  always #10 clock = ~clock;
  // async program memory
  assign instr_data = rom[instr_addr];
  always @(posedge clock) if (irq_ack === 1'b1) ack_count <= ack_count + 1;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [17:0] ik(mbiie_opcode_t o, logic [3:0] d, logic [7:0] v);
    return {o, 1'b0, d, v};
  endfunction
  function automatic logic [17:0] ir(mbiie_opcode_t o, logic [3:0] d, logic [3:0] s);
    return {o, 1'b0, d, s, 4'h0};
  endfunction
  function automatic logic [17:0] ij(mbiie_opcode_t o, logic [2:0] c, logic [9:0] t);
    return {o, c, t};
  endfunction
  task automatic finish_test();
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic hang();
    fail_count++;
    $display("CHECK FAILED wait exp 1 got 0");
    finish_test();
  endtask
  // 0 rvalid, 1 arready, 2 bvalid, 3 awready and wready, 4 irq_ack
  task automatic wait_hi(input int w);
    logic [4:0] v;
    for (int n = 0; n < 50; n++) begin
      @(negedge clock);
      v = {irq_ack, s_axi_awready & s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid};
      if (v[w] === 1'b1) return;
    end
    hang();
  endtask
  task automatic wait_pc(input logic [9:0] a);
    for (int n = 0; n < 400; n++) begin
      @(negedge clock);
      if (instr_addr === a) return;
    end
    hang();
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    wait_hi(3);
    @(posedge clock);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    wait_hi(2);
    r = s_axi_bresp;
    @(posedge clock);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wait_hi(1);
    @(posedge clock);
    s_axi_arvalid <= 1'b0;
    wait_hi(0);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clock);
    s_axi_rready <= 1'b0;
  endtask
  // request held through the acknowledge edge
  task automatic irq_pulse();
    @(posedge clock);
    irq_request <= 1'b1;
    wait_hi(4);
    @(posedge clock);
    irq_request <= 1'b0;
  endtask

  // ****************************************************************
  // program and sequence
  // ****************************************************************
  initial begin
    // stray execution leaves a write to port ee in the log
    for (int i = 0; i < 1024; i++) rom[i] = ik(OP_OUT_P, 4'h1, 8'hee);
    rom[0] = ik(OP_LOAD_K, 4'h1, 8'h5a);
    rom[1] = ik(OP_OUT_P, 4'h1, 8'h10);
    rom[2] = ir(OP_LOAD_R, 4'h2, 4'h1);
    rom[3] = ik(OP_OR_K, 4'h2, 8'h81);
    rom[4] = ij(OP_JUMP, COND_NZ, 10'h006);
    rom[6] = ij(OP_JUMP, COND_Z, 10'h005);
    rom[7] = ir(OP_OUT_R, 4'h2, 4'h1);
    rom[8] = ir(OP_OR_R, 4'h3, 4'h0);
    rom[9] = ij(OP_JUMP, COND_Z, 10'h00b);
    rom[11] = ij(OP_JUMP, COND_NZ, 10'h00a);
    rom[12] = ij(OP_JUMP, COND_C, 10'h00a);
    rom[13] = ij(OP_JUMP, COND_NC, 10'h00f);
    rom[15] = ik(OP_IN_P, 4'h4, 8'h20);
    rom[16] = ir(OP_IN_R, 4'h5, 4'h1);
    rom[17] = ik(OP_STORE_S, 4'h4, 8'h05);
    rom[18] = ik(OP_LOAD_K, 4'h6, 8'h06);
    rom[19] = ir(OP_STORE_R, 4'h5, 4'h6);
    rom[20] = ik(OP_FETCH_S, 4'h7, 8'h05);
    rom[21] = ir(OP_FETCH_R, 4'h8, 4'h6);
    rom[22] = ik(OP_OUT_P, 4'h7, 8'h30);
    rom[23] = ik(OP_OUT_P, 4'h8, 8'h31);
    rom[24] = ij(OP_JUMP, COND_ALWAYS, 10'h100);
    rom[256] = ik(OP_IRQ_ACCEPT_ON_INSTR, 4'h0, 8'h00);
    rom[257] = ij(OP_JUMP, COND_ALWAYS, 10'h101);
    rom[258] = ik(OP_OUT_P, 4'h1, 8'h40);
    rom[259] = ik(OP_IRQ_ACCEPT_ON_INSTR, 4'h0, 8'h00);
    rom[260] = ij(OP_JUMP, COND_ALWAYS, 10'h104);
    rom[261] = ik(OP_OUT_P, 4'h1, 8'h41);
    rom[262] = ij(OP_RETURN, COND_NZ, 10'h000);
    rom[263] = ij(OP_RETURN, COND_C, 10'h000);
    rom[264] = ik(OP_OUT_P, 4'h1, 8'h42);
    rom[265] = ij(OP_JUMP, COND_ALWAYS, 10'h109);
    rom[1023] = ij(OP_RETURN, COND_NC, 10'h000);
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    irq_request <= 1'b1;
    repeat (20) @(posedge clock);
    irq_request <= 1'b0;
    chk("ignored ack", 32'h0000_0000, ack_count);
    wait_pc(10'h101);
    irq_pulse();
    wait_pc(10'h104);
    axi_rd(ADDR_STATUS, rd, rs);
    chk("status after isr", 32'h0010_2d04, rd);
    rom[1023] = ij(OP_RETURN, COND_ALWAYS, 10'h000);
    irq_pulse();
    wait_pc(10'h109);
    axi_rd(ADDR_STATUS, rd, rs);
    chk("status end", 32'h0010_0d09, rd);
    axi_wr(ADDR_CTRL, 32'h0000_0000, rs);
    chk("ctrl resp", {30'h0, RESP_OKAY}, {30'h0, rs});
    axi_rd(ADDR_CTRL, rd, rs);
    chk("ctrl read", 32'h0000_0000, rd);
    axi_wr(ADDR_STATUS, 32'hffff_ffff, rs);
    chk("status wr resp", {30'h0, RESP_OKAY}, {30'h0, rs});
    axi_rd(ADDR_STATUS, rd, rs);
    chk("status halted", 32'h0010_0909, rd);
    axi_rd(4'h8, rd, rs);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    chk("unmapped data", 32'h0000_0000, rd);
    chk("ack count", 32'h0000_0002, ack_count);
    chk("write count", 32'h0000_0007, FAB.wr_n);
    for (int i = 0; i < 7; i++) chk("port write", exp_wr[i], FAB.wr_log[i]);
    chk("read count", 32'h0000_0002, FAB.rd_n);
    chk("read port 0", 32'h0000_0020, FAB.rd_log[0]);
    chk("read port 1", 32'h0000_005a, FAB.rd_log[1]);
    finish_test();
  end
endmodule

`default_nettype wire
